// >>> wsrf_reply_formatter.sv
`timescale 1ns/1ns
`include "wsrf_params.svh"
module wsrf_reply_formatter (
  // Clock, reset, enable
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  input  wire logic                   ce_i,
  // Command request
  input  wire logic                   req_valid_i,
  output logic                        req_ready_o,
  input  wire wsrf_pkg::wsrf_kind_e   req_kind_i,
  input  wire logic [1:0]             req_port_i,
  input  wire logic [15:0]            req_addr_i,
  input  wire logic [7:0]             req_cmd_i,
  input  wire logic [23:0]            req_sub_i,
  input  wire logic [1:0]             req_sub_len_i,
  input  wire logic [6:0]             req_err_num_i,
  input  wire logic [4:0]             format_mask_i,
  // Item data
  output wsrf_pkg::wsrf_item_e        item_sel_o,
  input  wire logic [55:0]            item_data_i,
  input  wire logic                   unit_kg_i,
  input  wire logic [7:0]             relay_status_i,
  input  wire logic [1:0]             excite_state_i,
  // Lamps
  input  wire logic                   lamp_pounds_i,
  input  wire logic                   lamp_zero_track_i,
  input  wire logic                   lamp_center_zero_i,
  input  wire logic                   lamp_motion_i,
  input  wire logic                   lamp_gross_i,
  input  wire logic                   lamp_net_i,
  input  wire logic                   lamp_kg_i,
  input  wire logic                   lamp_rate_i,
  input  wire logic                   lamp_alarm2_i,
  input  wire logic                   lamp_alarm1_i,
  input  wire logic                   lamp_peak_i,
  input  wire logic                   lamp_total_i,
  // Pins
  input  wire logic [7:0]             rear_switch_bank_i,
  input  wire logic [7:0]             internal_switch_bank_i,
  input  wire logic [7:0]             external_input_pick_i,
  // Decoded switches
  output logic                        serial_lockout_o,
  output logic                        ignore_checksum_o,
  output logic                        trade_approved_mode_o,
  // Reply stream
  output logic                        tx_valid_o,
  output logic [7:0]                  tx_byte_o,
  input  wire logic                   tx_ready_i,
  output logic [1:0]                  reply_port_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [7:0] hex_at(input logic [15:0] w,
                                        input logic [3:0]  i);
    case (i[1:0])
      2'h0:    hex_at = hex_ch(w[15:12]);
      2'h1:    hex_at = hex_ch(w[11:8]);
      2'h2:    hex_at = hex_ch(w[7:4]);
      default: hex_at = hex_ch(w[3:0]);
    endcase
  endfunction

  function automatic wsrf_pkg::wsrf_item_e first_item(input logic [12:0] m);
    first_item = wsrf_pkg::ITEM_NONE;
    for (int i = 12; i >= 0; i--) begin
      if (m[i]) begin
        first_item = wsrf_pkg::wsrf_item_e'(i[3:0]);
      end
    end
  endfunction

  function automatic wsrf_pkg::wsrf_item_e decode_sub(input logic [23:0] s,
                                                      input logic [1:0]  n);
    decode_sub = wsrf_pkg::ITEM_NONE;
    case (n)
      2'h1: begin
        case (s[23:16])
          `WSRF_SUB_TOTAL:  decode_sub = wsrf_pkg::ITEM_TOTAL;
          `WSRF_SUB_GROSS:  decode_sub = wsrf_pkg::ITEM_GROSS;
          `WSRF_SUB_NET:    decode_sub = wsrf_pkg::ITEM_NET;
          `WSRF_SUB_TARE:   decode_sub = wsrf_pkg::ITEM_TARE;
          `WSRF_SUB_PREACT: decode_sub = wsrf_pkg::ITEM_PREACT;
          `WSRF_SUB_SETPT:  decode_sub = wsrf_pkg::ITEM_SETPT;
          `WSRF_SUB_LAMP:   decode_sub = wsrf_pkg::ITEM_LAMP;
          `WSRF_SUB_RATE:   decode_sub = wsrf_pkg::ITEM_RATE;
          `WSRF_SUB_EXCITE: decode_sub = wsrf_pkg::ITEM_EXCITE;
          default:          decode_sub = wsrf_pkg::ITEM_NONE;
        endcase
      end
      2'h2: begin
        if (s[23:8] == `WSRF_SUB_BAND) begin
          decode_sub = wsrf_pkg::ITEM_DEADBAND;
        end else if (s[23:8] == `WSRF_SUB_SWITCH) begin
          decode_sub = wsrf_pkg::ITEM_SWITCH;
        end
      end
      2'h3: begin
        if (s == `WSRF_SUB_RELAY) begin
          decode_sub = wsrf_pkg::ITEM_RELAY;
        end else if (s == `WSRF_SUB_REMOTE) begin
          decode_sub = wsrf_pkg::ITEM_REMOTE;
        end
      end
      default: decode_sub = wsrf_pkg::ITEM_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [23:0] pin_s1_ff;
  logic [23:0] pin_s2_ff;
  logic [7:0]  rear_w;
  logic [7:0]  intl_w;
  logic [7:0]  rear_byte;
  logic [7:0]  intl_byte;
  logic [7:0]  lamp_b1;
  logic [7:0]  lamp_b2;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_ff <= 24'h000000;
      pin_s2_ff <= 24'h000000;
    end else if (ce_i) begin
      pin_s1_ff <= {rear_switch_bank_i, internal_switch_bank_i,
                    external_input_pick_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Bit i of a bank port is switch position i+1
  assign rear_w    = pin_s2_ff[23:16];
  assign intl_w    = pin_s2_ff[15:8];
  assign rear_byte = {rear_w[0], rear_w[2], rear_w[5], rear_w[7],
                      rear_w[6], rear_w[4], rear_w[3], rear_w[1]};
  assign intl_byte = {intl_w[5], intl_w[4], intl_w[2], intl_w[1],
                      intl_w[0], intl_w[3], intl_w[6], intl_w[7]};
  assign lamp_b1   = {lamp_kg_i, lamp_net_i, lamp_gross_i, lamp_motion_i,
                      lamp_center_zero_i, 1'b0, lamp_zero_track_i,
                      lamp_pounds_i};
  assign lamp_b2   = {3'h0, lamp_total_i, lamp_peak_i, lamp_alarm1_i,
                      lamp_alarm2_i, lamp_rate_i};

  assign serial_lockout_o      = rear_w[2];
  assign ignore_checksum_o     = intl_w[0];
  assign trade_approved_mode_o = intl_w[2];

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  wsrf_pkg::wsrf_phase_e phase_ff,   nxt_phase;
  wsrf_pkg::wsrf_phase_e shown_ff,   nxt_shown;
  wsrf_pkg::wsrf_kind_e  kind_ff,    nxt_kind;
  wsrf_pkg::wsrf_item_e  item_ff,    nxt_item;
  wsrf_pkg::wsrf_item_e  cur_item;
  wsrf_pkg::wsrf_item_e  req_item;
  logic [12:0]           pending_ff, nxt_pending;
  logic [3:0]            idx_ff,     nxt_idx;
  logic [15:0]           addr_ff,    nxt_addr;
  logic [7:0]            cmd_ff,     nxt_cmd;
  logic [23:0]           sub_ff,     nxt_sub;
  logic [1:0]            sublen_ff,  nxt_sublen;
  logic [6:0]            err_ff,     nxt_err;
  logic [1:0]            port_ff,    nxt_port;
  logic                  ready_ff,   nxt_ready;
  logic                  txv_ff,     nxt_txv;
  logic [7:0]            txb_ff,     nxt_txb;
  logic [12:0]           fmt_items;
  logic [15:0]           hexw;
  logic [15:0]           unit_w;
  logic [3:0]            blen;
  logic [55:0]           dsh;
  logic [23:0]           exc_sh;
  logic [7:0]            ch;
  logic [7:0]            sum_w;
  logic                  slot;
  logic                  chk_clear;
  logic                  chk_add;
  logic                  body_last;

  assign cur_item = first_item(pending_ff);
  assign req_item = decode_sub(req_sub_i, req_sub_len_i);
  assign dsh      = item_data_i << {idx_ff, 3'h0};
  assign slot     = !txv_ff || tx_ready_i;
  assign unit_w   = unit_kg_i ? `WSRF_UNIT_KG : `WSRF_UNIT_LB;

  always_comb begin
    fmt_items = 13'h0000;
    fmt_items[wsrf_pkg::ITEM_GROSS]    = format_mask_i[`WSRF_FMT_GROSS];
    fmt_items[wsrf_pkg::ITEM_NET]      = format_mask_i[`WSRF_FMT_NET];
    fmt_items[wsrf_pkg::ITEM_TARE]     = format_mask_i[`WSRF_FMT_TARE];
    fmt_items[wsrf_pkg::ITEM_RATE]     = format_mask_i[`WSRF_FMT_RATE];
    fmt_items[wsrf_pkg::ITEM_SETPT]    = format_mask_i[`WSRF_FMT_SETPT];
    fmt_items[wsrf_pkg::ITEM_DEADBAND] = format_mask_i[`WSRF_FMT_SETPT];
    fmt_items[wsrf_pkg::ITEM_PREACT]   = format_mask_i[`WSRF_FMT_SETPT];
  end

  // Body length and hex source for the item now being sent
  always_comb begin
    hexw   = 16'h0000;
    exc_sh = 24'h000000;
    blen   = `WSRF_DATA_LEN + 4'h2;
    case (cur_item)
      wsrf_pkg::ITEM_SWITCH: begin
        hexw = {rear_byte, intl_byte};
        blen = 4'h4;
      end
      wsrf_pkg::ITEM_LAMP: begin
        hexw = {lamp_b1, lamp_b2};
        blen = 4'h4;
      end
      wsrf_pkg::ITEM_RELAY: begin
        hexw = {relay_status_i, 8'h00};
        blen = 4'h2;
      end
      wsrf_pkg::ITEM_REMOTE: begin
        hexw = {pin_s2_ff[7:0], 8'h00};
        blen = 4'h2;
      end
      wsrf_pkg::ITEM_RATE: blen = `WSRF_DATA_LEN;
      wsrf_pkg::ITEM_EXCITE: begin
        blen = 4'h3;
        case (excite_state_i)
          2'h0:    exc_sh = `WSRF_EXC_OK;
          2'h1:    exc_sh = `WSRF_EXC_ERR;
          default: exc_sh = `WSRF_EXC_OFF;
        endcase
        exc_sh = exc_sh << {idx_ff, 3'h0};
      end
      default: blen = `WSRF_DATA_LEN + 4'h2;
    endcase
    if (kind_ff == wsrf_pkg::KIND_ERR) begin
      blen = 4'h2;
    end
  end

  always_comb begin
    nxt_phase   = phase_ff;
    nxt_shown   = shown_ff;
    nxt_kind    = kind_ff;
    nxt_pending = pending_ff;
    nxt_idx     = idx_ff;
    nxt_addr    = addr_ff;
    nxt_cmd     = cmd_ff;
    nxt_sub     = sub_ff;
    nxt_sublen  = sublen_ff;
    nxt_err     = err_ff;
    nxt_port    = port_ff;
    nxt_txv     = txv_ff && !tx_ready_i;
    nxt_txb     = txb_ff;
    chk_clear   = 1'b0;
    chk_add     = 1'b0;
    ch          = 8'h00;
    body_last   = (idx_ff + 4'h1) == blen;
    if (phase_ff == wsrf_pkg::PH_IDLE) begin
      if (req_valid_i && ready_ff) begin
        nxt_phase  = wsrf_pkg::PH_START;
        chk_clear  = 1'b1;
        nxt_kind   = req_kind_i;
        nxt_addr   = req_addr_i;
        nxt_cmd    = req_cmd_i;
        nxt_sub    = req_sub_i;
        nxt_sublen = req_sub_len_i;
        nxt_port   = req_port_i;
        nxt_err    = (req_err_num_i > `WSRF_ERR_MAX) ? `WSRF_ERR_MAX
                                                   : req_err_num_i;
        nxt_pending = fmt_items;
        if (req_kind_i == wsrf_pkg::KIND_DATA && req_sub_len_i != 2'h0) begin
          nxt_pending = 13'h0000;
          if (req_item == wsrf_pkg::ITEM_NONE) begin
            nxt_kind = wsrf_pkg::KIND_ERR;
            nxt_err  = `WSRF_ERR_BADSUB;
          end else begin
            nxt_pending[req_item] = 1'b1;
          end
        end
      end
    end else if (slot) begin
      nxt_txv   = 1'b1;
      nxt_shown = phase_ff;
      chk_add   = phase_ff >= wsrf_pkg::PH_ADDR &&
                  phase_ff <= wsrf_pkg::PH_CR;
      nxt_idx   = idx_ff + 4'h1;
      case (phase_ff)
        wsrf_pkg::PH_START: begin
          ch        = `WSRF_CH_START;
          nxt_phase = wsrf_pkg::PH_ADDR;
          nxt_idx   = 4'h0;
        end
        wsrf_pkg::PH_ADDR: begin
          ch = idx_ff[0] ? addr_ff[7:0] : addr_ff[15:8];
          if (idx_ff[0]) begin
            nxt_phase = wsrf_pkg::PH_CMD;
            nxt_idx   = 4'h0;
          end
        end
        wsrf_pkg::PH_CMD: begin
          nxt_idx = 4'h0;
          case (kind_ff)
            wsrf_pkg::KIND_ACK: begin
              ch        = `WSRF_CH_ACK;
              nxt_phase = wsrf_pkg::PH_CR;
            end
            wsrf_pkg::KIND_ERR: begin
              ch        = `WSRF_CH_NAK;
              nxt_phase = wsrf_pkg::PH_BODY;
            end
            default: begin
              ch        = cmd_ff;
              nxt_phase = (sublen_ff != 2'h0) ? wsrf_pkg::PH_SUB :
                          (pending_ff != 13'h0000) ? wsrf_pkg::PH_BODY :
                          wsrf_pkg::PH_CR;
            end
          endcase
        end
        wsrf_pkg::PH_SUB: begin
          case (idx_ff[1:0])
            2'h0:    ch = sub_ff[23:16];
            2'h1:    ch = sub_ff[15:8];
            default: ch = sub_ff[7:0];
          endcase
          if (idx_ff[1:0] + 2'h1 == sublen_ff) begin
            nxt_idx   = 4'h0;
            nxt_phase = (pending_ff != 13'h0000) ? wsrf_pkg::PH_BODY
                                                 : wsrf_pkg::PH_CR;
          end
        end
        wsrf_pkg::PH_BODY: begin
          if (kind_ff == wsrf_pkg::KIND_ERR) begin
            ch = `WSRF_CH_ZERO + {1'b0, (idx_ff[0] ? err_ff % 7'h0A
                                                   : err_ff / 7'h0A)};
          end else if (cur_item == wsrf_pkg::ITEM_EXCITE) begin
            ch = exc_sh[23:16];
          end else if (blen <= 4'h4) begin
            ch = hex_at(hexw, idx_ff);
          end else if (idx_ff < `WSRF_DATA_LEN) begin
            ch = dsh[55:48];
          end else if (idx_ff == `WSRF_DATA_LEN) begin
            ch = unit_w[15:8];
          end else begin
            ch = unit_w[7:0];
          end
          if (body_last) begin
            nxt_idx = 4'h0;
            if (kind_ff == wsrf_pkg::KIND_DATA) begin
              nxt_pending[cur_item] = 1'b0;
            end
            if (kind_ff != wsrf_pkg::KIND_DATA || nxt_pending == 13'h0000) begin
              nxt_phase = wsrf_pkg::PH_CR;
            end
          end
        end
        wsrf_pkg::PH_CR: begin
          ch        = `WSRF_CH_CR;
          nxt_phase = wsrf_pkg::PH_LF;
        end
        wsrf_pkg::PH_LF: begin
          ch        = `WSRF_CH_LF;
          nxt_phase = wsrf_pkg::PH_CK1;
        end
        wsrf_pkg::PH_CK1: begin
          ch        = hex_ch(sum_w[7:4]);
          nxt_phase = wsrf_pkg::PH_CK2;
        end
        wsrf_pkg::PH_CK2: begin
          ch        = hex_ch(sum_w[3:0]);
          nxt_phase = wsrf_pkg::PH_EOT;
        end
        wsrf_pkg::PH_EOT: begin
          ch        = `WSRF_CH_EOT;
          nxt_phase = wsrf_pkg::PH_IDLE;
        end
        default: nxt_phase = wsrf_pkg::PH_IDLE;
      endcase
      nxt_txb = ch;
    end
    nxt_item  = first_item(nxt_pending);
    nxt_ready = nxt_phase == wsrf_pkg::PH_IDLE;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_ff   <= wsrf_pkg::PH_IDLE;
      shown_ff   <= wsrf_pkg::PH_IDLE;
      kind_ff    <= wsrf_pkg::KIND_DATA;
      item_ff    <= wsrf_pkg::ITEM_NONE;
      pending_ff <= 13'h0000;
      idx_ff     <= 4'h0;
      addr_ff    <= 16'h0000;
      cmd_ff     <= 8'h00;
      sub_ff     <= 24'h000000;
      sublen_ff  <= 2'h0;
      err_ff     <= 7'h00;
      port_ff    <= 2'h0;
      ready_ff   <= 1'b0;
      txv_ff     <= 1'b0;
      txb_ff     <= 8'h00;
    end else if (ce_i) begin
      phase_ff   <= nxt_phase;
      shown_ff   <= nxt_shown;
      kind_ff    <= nxt_kind;
      item_ff    <= nxt_item;
      pending_ff <= nxt_pending;
      idx_ff     <= nxt_idx;
      addr_ff    <= nxt_addr;
      cmd_ff     <= nxt_cmd;
      sub_ff     <= nxt_sub;
      sublen_ff  <= nxt_sublen;
      err_ff     <= nxt_err;
      port_ff    <= nxt_port;
      ready_ff   <= nxt_ready;
      txv_ff     <= nxt_txv;
      txb_ff     <= nxt_txb;
    end
  end

  wsrf_chksum u_chksum (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .clear_i (chk_clear),
    .add_i   (chk_add),
    .byte_i  (ch),
    .sum_o   (sum_w)
  );

  assign req_ready_o  = ready_ff;
  assign item_sel_o   = item_ff;
  assign tx_valid_o   = txv_ff;
  assign tx_byte_o    = txb_ff;
  assign reply_port_o = port_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_frame_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (txv_ff && shown_ff == wsrf_pkg::PH_START) |-> txb_ff == `WSRF_CH_START)
    else $error("frame does not open with start char");
  a_lf_after_cr: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ce_i && txv_ff && tx_ready_i && shown_ff == wsrf_pkg::PH_CR) |=>
    (txv_ff && shown_ff == wsrf_pkg::PH_LF && txb_ff == `WSRF_CH_LF))
    else $error("line feed does not follow carriage return");
  a_ack_letter: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (txv_ff && shown_ff == wsrf_pkg::PH_CMD &&
     kind_ff == wsrf_pkg::KIND_ACK) |-> txb_ff == `WSRF_CH_ACK)
    else $error("acknowledge letter wrong");
  a_ack_short: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ce_i && txv_ff && tx_ready_i && shown_ff == wsrf_pkg::PH_CMD &&
     kind_ff == wsrf_pkg::KIND_ACK) |=> shown_ff == wsrf_pkg::PH_CR)
    else $error("acknowledge frame not short");
  a_err_digits: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (txv_ff && shown_ff == wsrf_pkg::PH_BODY &&
     kind_ff == wsrf_pkg::KIND_ERR) |-> txb_ff inside {[8'h30:8'h39]})
    else $error("error number not decimal ASCII");
  a_chk_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (txv_ff && shown_ff == wsrf_pkg::PH_CK2) |-> txb_ff == hex_ch(sum_w[3:0]))
    else $error("checksum low char wrong");
  a_eot_code: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ce_i && txv_ff && tx_ready_i && shown_ff == wsrf_pkg::PH_CK2) |=>
    (shown_ff == wsrf_pkg::PH_EOT && txb_ff == `WSRF_CH_EOT))
    else $error("end of transmission missing");
  // Lamp item is only ever sent alone, so item_ff marks every lamp char but the last
  a_lamp_hex: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (txv_ff && shown_ff == wsrf_pkg::PH_BODY &&
     item_ff == wsrf_pkg::ITEM_LAMP) |->
    txb_ff inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("lamp status not upper-case hex");

endmodule

// >>> wsrf_params.svh
// Function
// - Each data reply repeats the command frame, adds data and weight units, LF after CR; rate, lamp, switch, relay, remote, excite replies get no units.
// - Data reply: start, address, command, subcommand, 7 data, unit, CRLF, checksum, EOT.
// - No return data: start, address, letter A, CRLF, checksum, EOT.
// - Error: start, address, letter N, two decimal digits, CRLF, checksum, EOT.
// - Addresses, numbers and data travel as ASCII characters, never binary.
// - Transmit without subcommand sends the stored format's items to the asking port.
// - Subcommands pick total, gross, net, tare, band, preact, set point and more.
// - Lamp subcommand returns two status bytes, each as two hex characters.
// - Lamp byte one: lb, zero track, unused, center zero, motion, gross, net, kg.
// - Lamp byte two: rate, alarm two, alarm one, peak, total, three unused.
// - Switch subcommand returns rear bank byte, then internal bank byte.
// - Rear bank positions 1-8 map to bits 80,01,40,02,04,20,08,10.
// - Internal bank positions 1-8 map to bits 08,10,20,04,40,80,02,01.
// - Checksum sums address through CR modulo 256, two ASCII chars, then EOT.
`ifndef WSRF_PARAMS_SVH
`define WSRF_PARAMS_SVH

// ----------------------------------------
// Frame characters
// ----------------------------------------
`define WSRF_CH_START    8'h3E
`define WSRF_CH_CR       8'h0D
`define WSRF_CH_LF       8'h0A
`define WSRF_CH_EOT      8'h04
`define WSRF_CH_ACK      8'h41
`define WSRF_CH_NAK      8'h4E
`define WSRF_CH_ZERO     8'h30
`define WSRF_UNIT_LB     16'h4C62
`define WSRF_UNIT_KG     16'h4B67
`define WSRF_EXC_OK      24'h4F4B4B
`define WSRF_EXC_ERR     24'h455252
`define WSRF_EXC_OFF     24'h4F4646

// ----------------------------------------
// Subcommand codes
// ----------------------------------------
`define WSRF_SUB_TOTAL   8'h41
`define WSRF_SUB_GROSS   8'h47
`define WSRF_SUB_NET     8'h4E
`define WSRF_SUB_TARE    8'h54
`define WSRF_SUB_PREACT  8'h50
`define WSRF_SUB_SETPT   8'h53
`define WSRF_SUB_LAMP    8'h4C
`define WSRF_SUB_RATE    8'h43
`define WSRF_SUB_EXCITE  8'h45
`define WSRF_SUB_BAND    16'h4445
`define WSRF_SUB_SWITCH  16'h4449
`define WSRF_SUB_RELAY   24'h52454C
`define WSRF_SUB_REMOTE  24'h52454D

// ----------------------------------------
// Format mask bits and field sizes
// ----------------------------------------
`define WSRF_FMT_GROSS   0
`define WSRF_FMT_NET     1
`define WSRF_FMT_TARE    2
`define WSRF_FMT_RATE    3
`define WSRF_FMT_SETPT   4
`define WSRF_DATA_LEN    4'h7
`define WSRF_ERR_MAX     7'h63
`define WSRF_ERR_BADSUB  7'h01

`endif

// >>> wsrf_pkg.sv
package wsrf_pkg;

  typedef enum logic [1:0] {KIND_DATA, KIND_ACK, KIND_ERR} wsrf_kind_e;

  typedef enum logic [3:0] {
    ITEM_TOTAL, ITEM_GROSS, ITEM_NET, ITEM_TARE, ITEM_DEADBAND,
    ITEM_PREACT, ITEM_SETPT, ITEM_SWITCH, ITEM_LAMP, ITEM_RELAY,
    ITEM_REMOTE, ITEM_RATE, ITEM_EXCITE, ITEM_NONE
  } wsrf_item_e;

  typedef enum logic [3:0] {
    PH_IDLE, PH_START, PH_ADDR, PH_CMD, PH_SUB, PH_BODY, PH_CR, PH_LF,
    PH_CK1, PH_CK2, PH_EOT
  } wsrf_phase_e;

endpackage

// >>> wsrf_chksum.sv
`timescale 1ns/1ns
module wsrf_chksum (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  // Byte stream
  input  wire logic       clear_i,
  input  wire logic       add_i,
  input  wire logic [7:0] byte_i,
  // Running sum
  output logic      [7:0] sum_o
);

  logic [7:0] sum_ff;
  logic [7:0] nxt_sum;

  // Eight-bit wrap equals subtracting 256 until below 256
  always_comb begin
    nxt_sum = sum_ff;
    if (clear_i) begin
      nxt_sum = 8'h00;
    end else if (add_i) begin
      nxt_sum = sum_ff + byte_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sum_ff <= 8'h00;
    end else if (ce_i) begin
      sum_ff <= nxt_sum;
    end
  end

  assign sum_o = sum_ff;

endmodule

// >>> wsrf_host_model.sv
`timescale 1ns/1ns
module wsrf_host_model (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 nrst_i,
  // Host behaviour
  input  wire logic                 slow_i,
  input  wire wsrf_pkg::wsrf_item_e item_sel_i,
  output logic                      tx_ready_o,
  output logic [55:0]               item_data_o
);
  logic ready_ff;
  // Slow host stalls every other cycle so bytes must be held
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) ready_ff <= 1'b0;
    else ready_ff <= !slow_i || !ready_ff;
  end
  assign tx_ready_o = ready_ff;
  // Last digit names the item so a wrong pick shows in the reply
  assign item_data_o = {48'h303030313233, 8'h30 + 8'(item_sel_i)};
endmodule

// >>> weigh_serial_reply_formatter_bench.sv
`timescale 1ns/1ns
`include "wsrf_params.svh"
module weigh_serial_reply_formatter_bench;
  logic clock_i = 0, nrst_i = 0, ce_i = 1, req_valid_i = 0, unit_kg_i = 0;
  logic slow = 0, lmp = 0, tx_ready_i, req_ready_o, tx_valid_o;
  logic serial_lockout_o, ignore_checksum_o, trade_approved_mode_o;
  wsrf_pkg::wsrf_kind_e req_kind_i = wsrf_pkg::KIND_ACK;
  wsrf_pkg::wsrf_item_e item_sel_o;
  logic [1:0]  req_port_i = 2'h2, req_sub_len_i = 0, excite_state_i = 0;
  logic [1:0]  reply_port_o;
  logic [15:0] req_addr_i = 16'h3130;
  logic [7:0]  req_cmd_i = 8'h58, relay_status_i = 0, tx_byte_o;
  logic [7:0]  rear_switch_bank_i = 0, internal_switch_bank_i = 0;
  logic [7:0]  external_input_pick_i = 0;
  logic [23:0] req_sub_i = 0;
  logic [6:0]  req_err_num_i = 0;
  logic [4:0]  format_mask_i = 0;
  logic [55:0] item_data_i;
  wire lamp_pounds_i = lmp, lamp_zero_track_i = lmp, lamp_kg_i = lmp;
  wire lamp_center_zero_i = lmp, lamp_motion_i = lmp, lamp_gross_i = lmp;
  wire lamp_net_i = lmp, lamp_rate_i = lmp, lamp_alarm2_i = lmp;
  wire lamp_alarm1_i = lmp, lamp_peak_i = lmp, lamp_total_i = lmp;
  logic [7:0] exp[$], got[$], bd[$];
  int fail_count = 0, n_compared = 0;
  wsrf_reply_formatter dut_u (.*);
  wsrf_host_model host_u (.clock_i, .nrst_i, .slow_i(slow),
    .item_sel_i(item_sel_o), .tx_ready_o(tx_ready_i),
    .item_data_o(item_data_i));
  initial forever #5 clock_i = !clock_i;
  // Settled outputs; the byte is taken at the following rising edge
  always @(negedge clock_i) if (tx_valid_o === 1'b1 && tx_ready_i && ce_i)
    got.push_back(tx_byte_o);
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("Error %0t saw %h expected %h", $time, s, e);
    end
  endtask
  function logic [7:0] hx(input logic [3:0] n);
    return n < 10 ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task wt(input logic [7:0] id);
    bd = {bd, 8'h30, 8'h30, 8'h30, 8'h31, 8'h32, 8'h33, 8'h30 + id};
    bd = unit_kg_i ? {bd, 8'h4B, 8'h67} : {bd, 8'h4C, 8'h62};
  endtask
  // Frame is start, address, body, CR LF, checksum, EOT
  task run(input wsrf_pkg::wsrf_kind_e k, input logic [23:0] s,
           input logic [1:0] l, input logic [6:0] e);
    logic [7:0] ck;
    int t;
    ck = 8'h6E;
    foreach (bd[i]) ck += bd[i];
    exp = {8'h3E, 8'h31, 8'h30, bd, 8'h0D, 8'h0A, hx(ck[7:4]), hx(ck[3:0])};
    exp.push_back(8'h04);
    @(negedge clock_i);
    {req_kind_i, req_sub_i, req_sub_len_i, req_err_num_i} = {k, s, l, e};
    req_valid_i = 1;
    t = 0;
    while (req_ready_o !== 1'b1 && t < 50) begin
      @(negedge clock_i);
      t++;
    end
    @(negedge clock_i);
    req_valid_i = 0;
    check(8'(reply_port_o), 8'h02);
    while (got.size() < exp.size() && t < 300) begin
      @(negedge clock_i);
      t++;
    end
    foreach (exp[i]) check(got[i], exp[i]);
    got.delete();
  endtask
  initial begin
    logic [23:0] ex[3];
    ex = '{`WSRF_EXC_OK, `WSRF_EXC_ERR, `WSRF_EXC_OFF};
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    nrst_i = 1;
    bd = {8'h41};
    run(wsrf_pkg::KIND_ACK, 0, 0, 0);
    bd = {8'h4E, 8'h39, 8'h39};
    run(wsrf_pkg::KIND_ERR, 0, 0, 7'h63);
    bd = {8'h4E, 8'h30, 8'h31};
    run(wsrf_pkg::KIND_DATA, 24'h5A0000, 1, 0);
    slow = 1;
    bd = {8'h58, 8'h47};
    wt(1);
    run(wsrf_pkg::KIND_DATA, 24'h470000, 1, 0);
    slow = 0;
    unit_kg_i = 1;
    format_mask_i = 5'h01;
    bd = {8'h58};
    wt(1);
    run(wsrf_pkg::KIND_DATA, 0, 0, 0);
    lmp = 1;
    bd = {8'h58, 8'h4C, 8'h46, 8'h42, 8'h31, 8'h46};
    run(wsrf_pkg::KIND_DATA, 24'h4C0000, 1, 0);
    rear_switch_bank_i = 8'h85;
    internal_switch_bank_i = 8'h4F;
    bd = {8'h58, 8'h44, 8'h49, 8'h44, 8'h30, 8'h33, 8'h45};
    run(wsrf_pkg::KIND_DATA, 24'h444900, 2, 0);
    check(8'(serial_lockout_o), 8'h01);
    check(8'(ignore_checksum_o), 8'h01);
    check(8'(trade_approved_mode_o), 8'h01);
    external_input_pick_i = 8'hA5;
    relay_status_i = 8'h3C;
    bd = {8'h58, 8'h52, 8'h45, 8'h4D, 8'h41, 8'h35};
    run(wsrf_pkg::KIND_DATA, 24'h52454D, 3, 0);
    bd = {8'h58, 8'h52, 8'h45, 8'h4C, 8'h33, 8'h43};
    run(wsrf_pkg::KIND_DATA, 24'h52454C, 3, 0);
    bd = {8'h58, 8'h41};
    wt(0);
    run(wsrf_pkg::KIND_DATA, 24'h410000, 1, 0);
    bd = {8'h58, 8'h43};
    wt(11);
    bd = bd[0:$-2];
    run(wsrf_pkg::KIND_DATA, 24'h430000, 1, 0);
    format_mask_i = 5'h10;
    bd = {8'h58};
    wt(4);
    wt(5);
    wt(6);
    run(wsrf_pkg::KIND_DATA, 0, 0, 0);
    for (int c = 0; c < 3; c++) begin
      excite_state_i = 2'(c);
      bd = {8'h58, 8'h45, ex[c][23:16], ex[c][15:8], ex[c][7:0]};
      run(wsrf_pkg::KIND_DATA, 24'h450000, 1, 0);
    end
    give_verdict();
  end
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule
